// *** verilog/wake_status_irq_unit.sv ***
// Notes on behaviour
// - Interrupt on power-on or aux flag set, or debounced key event.
// - Status read clears power-on, aux flags and interrupt; low-battery only once recovered.
// - Key flag reads one when key pin is low, zero when high.
// - In active modes a key edge clears and starts the debounce counter.
// - At 8195 digital clock periods: update key flags, interrupt, stop.
// - Second edge on the same key before completion stops the counter.
// - Edge on another key before completion restarts the counter.
// - While debouncing, supply and clock-out enable bits read as one.
// - Interrupt cleared by status read or clear-interrupt command.
// - In OFF, a key held low wakes to IDLE, reset low, supplies on.
// - After key wake and digital supply ready, set key flag, interrupt.
// - Power-on wake edge sets its flag; only zero-to-one interrupts.
// - While power-on flag is one, supply and clock-out enables are one.
// - Wake input high never enters OFF; unused input is grounded.
// - Low-battery flag sets on low supply, clears on recovery plus read.
// - In OFF, aux supply high enters AUX, sets aux flag, interrupts.
// - Active aux edge sets aux flag; only zero-to-one interrupts.
// - Serial transfers are bytes, command first, MSB first.
// - While command shifts in, data buffer byte count shifts out.
// - Serial logic held in reset while chip select is low.
// - Buffer writes echo command and data; buffer reads pop bytes.
// - Command top three bits select type, low five give address.
// - Clear-interrupt command drives the interrupt output low.
`timescale 1ns/1ps
module wake_status_irq_unit
  import wake_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = DEBOUNCE_TICKS_DOC
)
(
  input wire logic MCLK, // system clock, 50 MHz
  input wire logic RESET, // asynchronous reset, active high
  input wire serial_pins_t SERIAL, // chip select, serial clock, serial_in
  output logic SERIAL_OUT, // serial_out data
  output logic SERIAL_OUT_OE, // serial_out enable, high while driven
  input wire logic [NUM_KEYS-1:0] KEY, // key_input pins, low when pressed
  input wire logic WAKE, // wake_input pin
  input wire monitor_t MONITOR, // supply comparator levels
  output logic IRQ, // interrupt request, active high
  output logic RESET_OUT_N, // reset to host, active low
  output logic SUPPLY_EN, // internal supplies enabled
  output logic EXT_SUPPLY_EN, // ext_supply_enable
  output logic CLK_OUT_EN // clock output enable
);

  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(DCLK_CYCLES - 1);

  typedef struct packed
  {
    mode_t mode;
    logic [1:0] wake_s;
    logic wake_d;
    monitor_t mon_s0;
    monitor_t mon_s1;
    logic aux_d;
    logic [7:0] status;
    logic irq;
    logic pend_key;
    logic pend_pwr;
    logic [NUM_CTRL-1:0][7:0] cr;
    logic [BUF_DEPTH-1:0][7:0] data_buf;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    cmd_t cmd;
    logic [4:0] addr;
    logic tx_load;
    logic [7:0] tx_byte;
    logic [DIV_W-1:0] div;
    logic tick;
    logic sup_en;
    logic ext_en;
    logic clk_en;
    logic rst_n;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  logic [7:0] rx_byte;
  logic rx_done;
  logic byte_first;
  logic ser_start;
  logic [NUM_KEYS-1:0] key_level;
  logic deb_done;
  logic deb_running;

  serial_link u_link
  (
    .clk(MCLK),
    .reset(RESET),
    .pins(SERIAL),
    .tx_load(s.tx_load),
    .tx_byte(s.tx_byte),
    .rx_byte(rx_byte),
    .rx_done(rx_done),
    .byte_first(byte_first),
    .start(ser_start),
    .sdo(SERIAL_OUT),
    .sdo_oe(SERIAL_OUT_OE)
  );

  key_debounce #(.TICKS(DEBOUNCE_TICKS)) u_debounce
  (
    .clk(MCLK),
    .reset(RESET),
    .tick(s.tick),
    .keys(KEY),
    .level(key_level),
    .done(deb_done),
    .running(deb_running)
  );

  function automatic logic [7:0] reg_read(
    input logic [4:0] a,
    input logic [NUM_CTRL-1:0][7:0] cr,
    input logic [7:0] st,
    input logic force_on
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_STATUS)
      v = st;
    else if (a < 5'(NUM_CTRL))
    begin
      v = cr[a[2:0]];
      if (a == ADDR_CR3 && force_on)
      begin
        v[CR3_EXT_SUPPLY] = 1'b1;
        v[CR3_CLK_OUT] = 1'b1;
      end
    end
    return v;
  endfunction

  always_comb
  begin
    cmd_t cmd;
    logic [4:0] addr;
    logic wake_rise;
    logic aux_rise;
    logic force_on;
    logic digital_supply_ok;
    cmd = s.cmd;
    addr = s.addr;
    wake_rise = s.wake_s[1] & ~s.wake_d;
    aux_rise = s.mon_s1.aux_over_main & ~s.aux_d;
    force_on = deb_running | s.status[ST_POWER_ON];
    digital_supply_ok = s.mon_s1.digital_supply_ready;
    next_s = s;
    next_s.tx_load = 1'b0;
    next_s.wake_s = {s.wake_s[0], WAKE};
    next_s.wake_d = s.wake_s[1];
    next_s.mon_s0 = MONITOR;
    next_s.mon_s1 = s.mon_s0;
    next_s.aux_d = s.mon_s1.aux_over_main;
    next_s.tick = 1'b0;
    if (s.div == DIV_MAX)
    begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.div = s.div + DIV_W'(1);

    // Serial side first, so that an event in the same cycle wins.
    if (ser_start)
    begin
      next_s.tx_byte = {3'h0, s.count};
      next_s.tx_load = 1'b1;
    end
    if (rx_done)
    begin
      if (byte_first)
      begin
        cmd = cmd_t'(rx_byte[7:5]);
        addr = rx_byte[4:0];
        next_s.cmd = cmd;
        next_s.addr = addr;
      end
      case (cmd)
        CMD_RD_REG:
        begin
          next_s.tx_byte = reg_read(addr, s.cr, s.status, force_on);
          next_s.tx_load = 1'b1;
          next_s.addr = addr + 5'h01;
          if (addr == ADDR_STATUS)
          begin
            next_s.status[ST_POWER_ON] = 1'b0;
            next_s.status[ST_AUX] = 1'b0;
            next_s.irq = 1'b0;
            if (s.mon_s1.external_supply_output_recovered)
              next_s.status[ST_LOW_BATT] = 1'b0;
          end
        end
        CMD_WR_REG:
        begin
          next_s.tx_byte = rx_byte;
          next_s.tx_load = 1'b1;
          if (!byte_first)
          begin
            if (addr < 5'(NUM_CTRL))
              next_s.cr[addr[2:0]] = rx_byte;
            next_s.addr = addr + 5'h01;
          end
        end
        CMD_RD_BUF:
        begin
          next_s.tx_byte = 8'h00;
          next_s.tx_load = 1'b1;
          if (s.count != '0)
          begin
            next_s.tx_byte = s.data_buf[s.rd_ptr];
            next_s.rd_ptr = s.rd_ptr + PTR_W'(1);
            next_s.count = s.count - CNT_W'(1);
          end
        end
        CMD_WR_BUF:
        begin
          next_s.tx_byte = rx_byte;
          next_s.tx_load = 1'b1;
          if (!byte_first && s.count != CNT_W'(BUF_DEPTH))
          begin
            next_s.data_buf[s.wr_ptr] = rx_byte;
            next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
            next_s.count = s.count + CNT_W'(1);
          end
        end
        CMD_OFF:
        begin
          // Refused while wake is high or a key is held, so the wake
          // input can never be what puts the part to sleep.
          if (byte_first && !s.wake_s[1] && (&key_level) &&
              !s.cr[ADDR_CR1[2:0]][CR1_ANALOG_EN])
            next_s.mode = MODE_OFF;
        end
        CMD_DEL_IRQ:
        begin
          if (byte_first)
            next_s.irq = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    if (s.mon_s1.external_supply_output_low)
      next_s.status[ST_LOW_BATT] = 1'b1;

    if (s.mode == MODE_OFF)
    begin
      if (deb_done && !(&key_level))
      begin
        next_s.mode = MODE_IDLE;
        next_s.pend_key = 1'b1;
      end
      else if (wake_rise)
      begin
        next_s.mode = MODE_IDLE;
        next_s.pend_pwr = 1'b1;
      end
      else if (s.mon_s1.aux_ok)
      begin
        next_s.mode = MODE_AUX;
        next_s.status[ST_AUX] = 1'b1;
        next_s.irq = 1'b1;
      end
    end
    else
    begin
      if (deb_done)
      begin
        next_s.status[ST_KEY_LSB +: NUM_KEYS] = ~key_level;
        next_s.irq = 1'b1;
      end
      if (s.pend_key && digital_supply_ok)
      begin
        next_s.pend_key = 1'b0;
        next_s.status[ST_KEY_LSB +: NUM_KEYS] = ~key_level;
        next_s.irq = 1'b1;
      end
      if (s.pend_pwr && digital_supply_ok)
      begin
        next_s.pend_pwr = 1'b0;
        next_s.status[ST_POWER_ON] = 1'b1;
        next_s.irq = 1'b1;
      end
      if (wake_rise)
      begin
        next_s.status[ST_POWER_ON] = 1'b1;
        if (!s.status[ST_POWER_ON])
          next_s.irq = 1'b1;
      end
      if (aux_rise)
      begin
        next_s.status[ST_AUX] = 1'b1;
        if (!s.status[ST_AUX])
          next_s.irq = 1'b1;
      end
    end

    next_s.sup_en = (s.mode != MODE_OFF);
    next_s.rst_n = (s.mode != MODE_OFF) && s.mon_s1.supply_good;
    next_s.ext_en = s.cr[ADDR_CR3[2:0]][CR3_EXT_SUPPLY] | force_on;
    next_s.clk_en = s.cr[ADDR_CR3[2:0]][CR3_CLK_OUT] | force_on;
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      s <= '{mode: MODE_IDLE, status: STATUS_RESET,
             cr: {NUM_CTRL{CTRL_RESET}}, cmd: CMD_RD_BUF, default: '0};
    else
      s <= next_s;
  end

  assign IRQ = s.irq;
  assign RESET_OUT_N = s.rst_n;
  assign SUPPLY_EN = s.sup_en;
  assign EXT_SUPPLY_EN = s.ext_en;
  assign CLK_OUT_EN = s.clk_en;

endmodule

// *** verilog/wake_pkg.sv ***
package wake_pkg;

  localparam int MCLK_PERIOD_NS = 20;
  localparam int DCLK_PERIOD_NS = 320;
  localparam int DCLK_CYCLES =
    (DCLK_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int DEBOUNCE_TICKS_DOC = 8195;
  localparam int DEB_CNT_W = 14;
  localparam int DIV_W = 8;

  localparam int NUM_CTRL = 8;
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int NUM_KEYS = 5;

  localparam logic [4:0] ADDR_CR1 = 5'h00;
  localparam logic [4:0] ADDR_CR3 = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h08;

  localparam int ST_KEY_LSB = 0;
  localparam int ST_POWER_ON = 5;
  localparam int ST_LOW_BATT = 6;
  localparam int ST_AUX = 7;
  localparam int CR3_EXT_SUPPLY = 2;
  localparam int CR3_CLK_OUT = 1;
  localparam int CR1_ANALOG_EN = 6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [2:0]
  {
    CMD_RD_BUF = 3'b000,
    CMD_WR_BUF = 3'b001,
    CMD_RD_REG = 3'b010,
    CMD_WR_REG = 3'b011,
    CMD_OFF = 3'b100,
    CMD_DEL_IRQ = 3'b101,
    CMD_UNUSED6 = 3'b110,
    CMD_UNUSED7 = 3'b111
  } cmd_t;

  typedef enum logic [1:0]
  {
    MODE_OFF = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_AUX = 2'b10
  } mode_t;

  typedef struct packed
  {
    logic cs;
    logic sck;
    logic sdi;
  } serial_pins_t;

  typedef struct packed
  {
    logic aux_ok;
    logic aux_over_main;
    logic external_supply_output_low;
    logic external_supply_output_recovered;
    logic digital_supply_ready;
    logic supply_good;
  } monitor_t;

endpackage

// *** verilog/serial_link.sv ***
`timescale 1ns/1ps
module serial_link
  import wake_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // asynchronous reset, active high
  input wire serial_pins_t pins, // raw chip select, clock and data in
  input wire logic tx_load, // load tx_byte for shifting out
  input wire logic [7:0] tx_byte, // next byte to shift out
  output logic [7:0] rx_byte, // last byte received
  output logic rx_done, // pulse: a byte has been received
  output logic byte_first, // rx_byte is the command byte
  output logic start, // pulse: chip select went high
  output logic sdo, // serial data out
  output logic sdo_oe // serial data out enable
);

  typedef struct packed
  {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic sck_d;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] tx_sh;
    logic first;
    logic done;
    logic active;
    logic start;
  } link_state_t;

  link_state_t s;
  link_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.start = 1'b0;
    next_s.cs_s = {s.cs_s[0], pins.cs};
    next_s.sck_s = {s.sck_s[0], pins.sck};
    next_s.sdi_s = {s.sdi_s[0], pins.sdi};
    next_s.sck_d = s.sck_s[1];
    if (!s.cs_s[1])
    begin
      next_s.rx_sh = 8'h00;
      next_s.bit_cnt = 3'h0;
      next_s.tx_sh = 8'h00;
      next_s.first = 1'b1;
      next_s.active = 1'b0;
    end
    else
    begin
      if (!s.active)
      begin
        next_s.active = 1'b1;
        next_s.start = 1'b1;
      end
      if (s.sck_s[1] && !s.sck_d)
      begin
        next_s.rx_sh = {s.rx_sh[6:0], s.sdi_s[1]};
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == 3'h7)
          next_s.done = 1'b1;
      end
      // The falling edge after the eighth bit must not shift: the reply
      // byte has already been loaded and its first bit has to stay out.
      if (!s.sck_s[1] && s.sck_d && s.bit_cnt != 3'h0)
        next_s.tx_sh = {s.tx_sh[6:0], 1'b0};
      if (tx_load)
        next_s.tx_sh = tx_byte;
      if (s.done)
        next_s.first = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign rx_byte = s.rx_sh;
  assign rx_done = s.done;
  assign byte_first = s.first;
  assign start = s.start;
  assign sdo = s.tx_sh[7];
  assign sdo_oe = s.cs_s[1];

endmodule

// *** verilog/key_debounce.sv ***
`timescale 1ns/1ps
module key_debounce
  import wake_pkg::*;
#(
  parameter int TICKS = DEBOUNCE_TICKS_DOC
)
(
  input wire logic clk, // system clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic tick, // one digital clock period enable
  input wire logic [NUM_KEYS-1:0] keys, // raw key pins
  output logic [NUM_KEYS-1:0] level, // synchronised key levels
  output logic done, // pulse: debounce run completed
  output logic running // debounce counter is running
);

  typedef struct packed
  {
    logic [NUM_KEYS-1:0] k0;
    logic [NUM_KEYS-1:0] k1;
    logic [NUM_KEYS-1:0] kd;
    logic [DEB_CNT_W-1:0] cnt;
    logic [2:0] owner;
    logic running;
    logic done;
  } deb_state_t;

  deb_state_t s;
  deb_state_t next_s;

  function automatic logic [2:0] lowest(input logic [NUM_KEYS-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_KEYS - 1; i >= 0; i--)
      if (v[i])
        idx = 3'(i);
    return idx;
  endfunction

  always_comb
  begin
    logic [NUM_KEYS-1:0] edges;
    logic [NUM_KEYS-1:0] others;
    edges = s.k1 ^ s.kd;
    others = edges;
    next_s = s;
    next_s.k0 = keys;
    next_s.k1 = s.k0;
    next_s.kd = s.k1;
    next_s.done = 1'b0;
    if (s.running)
      others[s.owner] = 1'b0;
    if (|others)
    begin
      next_s.running = 1'b1;
      next_s.cnt = '0;
      next_s.owner = lowest(others);
    end
    else if (s.running && edges[s.owner])
      next_s.running = 1'b0;
    else if (s.running && tick)
    begin
      if (s.cnt == DEB_CNT_W'(TICKS - 1))
      begin
        next_s.running = 1'b0;
        next_s.done = 1'b1;
      end
      else
        next_s.cnt = s.cnt + DEB_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s <= '{k0: '1, k1: '1, kd: '1, default: '0};
    else
      s <= next_s;
  end

  assign level = s.k1;
  assign done = s.done;
  assign running = s.running;

endmodule

// *** testbench/wake_sva.sv ***
`timescale 1ns/1ps
module wake_sva
  import wake_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = DEBOUNCE_TICKS_DOC
)
(
  input wire logic MCLK, // system clock
  input wire logic RESET, // asynchronous reset
  input wire serial_pins_t SERIAL, // serial pins in
  input wire logic SERIAL_OUT, // serial data out
  input wire logic SERIAL_OUT_OE, // serial data out enable
  input wire logic [NUM_KEYS-1:0] KEY, // key pins
  input wire logic WAKE, // wake pin
  input wire monitor_t MONITOR, // supply levels
  input wire logic IRQ, // interrupt request
  input wire logic RESET_OUT_N, // reset to host
  input wire logic SUPPLY_EN, // supplies on
  input wire logic EXT_SUPPLY_EN, // external supply enable
  input wire logic CLK_OUT_EN // clock output enable
);
  // Longest debounce with tick phase and synchronisers, plus margin.
  localparam int QUIET = DEBOUNCE_TICKS * 16 + 40;
  int quiet_cnt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  always_ff @(posedge MCLK or posedge RESET)
    if (RESET)
      quiet_cnt <= 0;
    else if ($changed(KEY) || $changed(WAKE) || $changed(MONITOR))
      quiet_cnt <= 0;
    else if (quiet_cnt < QUIET)
      quiet_cnt <= quiet_cnt + 1;
  AST_OE_OFF: assert property (!SERIAL.cs [*4] |-> !SERIAL_OUT_OE)
    else $error("serial out driven while deselected");
  AST_OE_ON: assert property (SERIAL.cs [*5] |-> SERIAL_OUT_OE)
    else $error("serial out not driven in frame");
  AST_KEY_EN: assert property ($changed(KEY) |->
    ##[1:6] (EXT_SUPPLY_EN && CLK_OUT_EN))
    else $error("enables not forced during debounce");
  AST_WAKE_EN: assert property ($rose(WAKE) |->
    ##[1:6] (EXT_SUPPLY_EN && CLK_OUT_EN))
    else $error("enables not forced by wake flag");
  AST_SUPPLY: assert property (RESET_OUT_N |-> SUPPLY_EN)
    else $error("reset released without supplies");
  AST_IRQ_FALL: assert property ($fell(IRQ) |-> SERIAL_OUT_OE)
    else $error("interrupt dropped without host access");
  AST_QUIET: assert property (quiet_cnt >= QUIET |-> !$rose(IRQ))
    else $error("interrupt without a cause");
  AST_OFF_REFUSED: assert property (WAKE [*5] |=> !$fell(SUPPLY_EN))
    else $error("off entered while wake high");
  cover property ($rose(IRQ));
  cover property ($fell(IRQ));
  cover property ($rose(WAKE) ##[1:6] IRQ);
endmodule

bind wake_status_irq_unit wake_sva #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) chk (
  .MCLK, .RESET, .SERIAL, .SERIAL_OUT, .SERIAL_OUT_OE, .KEY, .WAKE,
  .MONITOR, .IRQ, .RESET_OUT_N, .SUPPLY_EN, .EXT_SUPPLY_EN, .CLK_OUT_EN);

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
module host_model
  import wake_pkg::*;
(
  output serial_pins_t pins, // chip select, clock and data
  input wire logic sdo // serial data from the unit
);
  initial pins = '0;
  // Released data shows the inverse of its last bit, so nothing that
  // samples it outside a bit slot can match by luck.
  task automatic frame(input logic on);
    pins.cs = on;
    pins.sdi = ~pins.sdi;
    #200;
  endtask
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      pins.sdi = t[i];
      #80 pins.sck = 1'b1;
      r[i] = sdo;
      #80 pins.sck = 1'b0;
    end
    pins.sdi = ~pins.sdi;
    #200;
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import wake_pkg::*;
  localparam int TICKS = 4;
  logic MCLK;
  logic RESET;
  serial_pins_t SERIAL;
  logic SERIAL_OUT, SERIAL_OUT_OE, IRQ, RESET_OUT_N;
  logic SUPPLY_EN, EXT_SUPPLY_EN, CLK_OUT_EN, WAKE;
  logic [NUM_KEYS-1:0] KEY;
  monitor_t MONITOR;
  logic [7:0] tx [3];
  logic [7:0] rx [3];
  int num_errors = 0;
  int comparisons = 0;

  wake_status_irq_unit #(.DEBOUNCE_TICKS(TICKS)) dut (.MCLK, .RESET,
    .SERIAL, .SERIAL_OUT, .SERIAL_OUT_OE, .KEY, .WAKE, .MONITOR, .IRQ,
    .RESET_OUT_N, .SUPPLY_EN, .EXT_SUPPLY_EN, .CLK_OUT_EN);
  host_model host (.pins(SERIAL), .sdo(SERIAL_OUT));

  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic run(input int n);
    tick(1);
    host.frame(1'b1);
    for (int i = 0; i < n; i++)
      host.xfer(tx[i], rx[i]);
    host.frame(1'b0);
  endtask
  task automatic rd(input logic [4:0] a);
    tx[0] = {3'b010, a};
    tx[1] = 8'h00;
    run(2);
  endtask
  task automatic s_reset();
    check({7'h00, IRQ}, 8'h00);
    check({7'h00, SERIAL_OUT_OE}, 8'h00);
    rd(5'h08);
    check(rx[0], 8'h00);
    check(rx[1], STATUS_RESET);
  endtask
  task automatic s_key();
    KEY = 5'h1A;
    tick(20);
    check({6'h00, EXT_SUPPLY_EN, CLK_OUT_EN}, 8'h03);
    check({7'h00, IRQ}, 8'h00);
    tick(TICKS * 16 + 40);
    check({7'h00, IRQ}, 8'h01);
    rd(5'h08);
    check(rx[1], 8'h05);
    check({7'h00, IRQ}, 8'h00);
  endtask
  task automatic s_same();
    KEY = 5'h1E;
    tick(20);
    KEY = 5'h1A;
    tick(150);
    check({7'h00, IRQ}, 8'h00);
    rd(5'h08);
    check(rx[1], 8'h05);
  endtask
  task automatic s_other();
    KEY = 5'h1B;
    tick(40);
    KEY = 5'h13;
    tick(35);
    check({7'h00, IRQ}, 8'h00);
    tick(60);
    check({7'h00, IRQ}, 8'h01);
    rd(5'h08);
    check(rx[1], 8'h0C);
  endtask
  task automatic s_wake();
    WAKE = 1'b1;
    tick(10);
    check({7'h00, IRQ}, 8'h01);
    rd(ADDR_CR3);
    check(rx[1], 8'h06);
    tx[0] = 8'h80;
    run(1);
    check({7'h00, SUPPLY_EN}, 8'h01);
    tx[0] = 8'hA0;
    run(1);
    check({7'h00, IRQ}, 8'h00);
    WAKE = 1'b0;
    tick(10);
    WAKE = 1'b1;
    tick(10);
    check({7'h00, IRQ}, 8'h00);
    rd(5'h08);
    check(rx[1], 8'h2C);
    rd(5'h08);
    check(rx[1], 8'h0C);
    check({6'h00, EXT_SUPPLY_EN, CLK_OUT_EN}, 8'h00);
  endtask
  task automatic s_aux();
    MONITOR.aux_over_main = 1'b1;
    tick(10);
    check({7'h00, IRQ}, 8'h01);
    MONITOR.external_supply_output_low = 1'b1;
    MONITOR.external_supply_output_recovered = 1'b0;
    tick(10);
    rd(5'h08);
    check(rx[1], 8'hCC);
    check({7'h00, IRQ}, 8'h00);
    rd(5'h08);
    check(rx[1], 8'h4C);
    MONITOR.external_supply_output_low = 1'b0;
    MONITOR.external_supply_output_recovered = 1'b1;
    tick(10);
    rd(5'h08);
    rd(5'h08);
    check(rx[1], 8'h0C);
  endtask
  task automatic s_regs();
    tx = '{8'h63, 8'h5A, 8'hA5};
    run(3);
    check(rx[1], 8'h63);
    check(rx[2], 8'h5A);
    tx = '{8'h43, 8'h00, 8'h00};
    run(3);
    check(rx[1], 8'h5A);
    check(rx[2], 8'hA5);
    rd(5'h09);
    check(rx[1], 8'h00);
  endtask
  task automatic s_buf();
    tx = '{8'h20, 8'h11, 8'h22};
    run(3);
    check(rx[0], 8'h00);
    check(rx[2], 8'h11);
    tx[0] = 8'hC0;
    run(1);
    tx[0] = 8'hE0;
    run(1);
    tx = '{8'h00, 8'h00, 8'h00};
    run(3);
    check(rx[0], 8'h02);
    check(rx[1], 8'h11);
    check(rx[2], 8'h22);
  endtask
  task automatic s_off();
    KEY = 5'h1F;
    WAKE = 1'b0;
    tick(100);
    rd(5'h08);
    check(rx[1], 8'h00);
    tx[0] = 8'h80;
    run(1);
    check({6'h00, SUPPLY_EN, RESET_OUT_N}, 8'h00);
    MONITOR.supply_good = 1'b0;
    KEY = 5'h1E;
    tick(100);
    check({6'h00, SUPPLY_EN, RESET_OUT_N}, 8'h02);
    check({7'h00, IRQ}, 8'h01);
    MONITOR.supply_good = 1'b1;
    tick(5);
    check({7'h00, RESET_OUT_N}, 8'h01);
    rd(5'h08);
    check(rx[1], 8'h01);
    KEY = 5'h1F;
    tick(100);
    rd(5'h08);
    tx[0] = 8'h80;
    run(1);
    check({7'h00, SUPPLY_EN}, 8'h00);
    MONITOR.aux_ok = 1'b1;
    tick(10);
    check({6'h00, SUPPLY_EN, IRQ}, 8'h03);
    rd(5'h08);
    check(rx[1], 8'h80);
  endtask
  task automatic summarize();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    RESET = 1'b1;
    KEY = 5'h1F;
    WAKE = 1'b0;
    MONITOR = 6'b000111;
    repeat (20) @(posedge MCLK);
    #1;
    RESET = 1'b0;
    tick(5);
    s_reset();
    s_key();
    s_same();
    s_other();
    s_wake();
    s_aux();
    s_regs();
    s_buf();
    s_off();
    summarize();
  end

  // The whole sequence needs well under 200 us.
  initial
  begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule
